// file: design/adc_decimation_filter_control.sv
// Decimation filter control: register, rate timing and converter restart.
// Assumes an AXI4-Lite master on aclk and a filter datapath that takes
// the settings, the modulator tick and the converter reset pulse.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module adc_decimation_filter_control
    import adc_filter_pkg::*;
#(
    parameter int DELAY_CYCLES = CONVERTER_DELAY_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic converter_reset,
    output logic modulator_tick,
    output logic result_strobe,
    output logic chop_active,
    output logic running_average_active,
    output logic [5:0] averaging_factor,
    output logic second_notch_enable,
    output logic [6:0] decimation_factor,
    output logic low_power_mode
);
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_DELAY,
        SEQ_SETTLE,
        SEQ_RUN
    } seq_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] filter_ctrl;
        logic [2:0] mode_ctrl;
        logic restart;
        logic converter_reset;
        seq_type seq;
        logic [15:0] delay_cnt;
        logic [17:0] tick_cnt;
        logic [2:0] settle_cnt;
        logic result_strobe;
        logic ravg_active;
    } ctrl_state_type;

    localparam ctrl_state_type RESET_STATE = '{
        awready: 1'b1,
        wready: 1'b1,
        aw_held: 1'b0,
        aw_addr: 32'h0,
        w_held: 1'b0,
        w_data: 16'h0,
        w_strb: 2'h0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: 32'h0,
        rresp: RESP_OKAY,
        filter_ctrl: FILTER_CONTROL_RESET,
        mode_ctrl: MODE_CONTROL_RESET,
        restart: 1'b1,
        converter_reset: 1'b0,
        seq: SEQ_IDLE,
        delay_cnt: 16'h0,
        tick_cnt: 18'h0,
        settle_cnt: 3'h0,
        result_strobe: 1'b0,
        ravg_active: 1'b0
    };

    ctrl_state_type state;
    ctrl_state_type next_state;
    logic [17:0] period;
    logic [2:0] settle_periods;
    logic tick;
    logic [1:0] enabled_count;
    logic [31:0] read_word;

    // ------------------------------------------------------------
    // Modulator tick and rate calculation
    // ------------------------------------------------------------
    modulator_ticker ticker (
        .aclk(aclk),
        .aresetn(aresetn),
        .low_power(state.mode_ctrl[MODE_LOW_POWER_BIT]),
        .tick(tick)
    );

    rate_period_calc calc (
        .aclk(aclk),
        .aresetn(aresetn),
        .sf(state.filter_ctrl[SF_LSB +: 7]),
        .af(state.filter_ctrl[AF_LSB +: 6]),
        .chop(state.filter_ctrl[CHOP_BIT]),
        .ravg(state.ravg_active),
        .low_power(state.mode_ctrl[MODE_LOW_POWER_BIT]),
        .period(period),
        .settle_periods(settle_periods)
    );

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always_comb begin
        read_word = 32'h0;
        if (s_axi_araddr == FILTER_CONTROL_ADDR) begin
            read_word[15:0] = state.filter_ctrl;
        end else if (s_axi_araddr == MODE_CONTROL_ADDR) begin
            read_word[2:0] = state.mode_ctrl;
        end else if (s_axi_araddr == FILTER_STATUS_ADDR) begin
            read_word[17:0] = period;
            read_word[STATUS_SETTLE_LSB +: 3] = settle_periods;
            read_word[STATUS_SEQ_LSB +: 2] = state.seq;
        end
    end

    // Enabled converter count for the start delay
    assign enabled_count =
        2'(state.mode_ctrl[MODE_PRIMARY_BIT]) +
        2'(state.mode_ctrl[MODE_AUX_BIT]);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.converter_reset = 1'b0;
        next_state.result_strobe = 1'b0;

        // Write address and data are taken independently
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata[15:0];
            next_state.w_strb = s_axi_wstrb[1:0];
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // Commit once both halves are held and no answer is pending
        if (state.aw_held && state.w_held && !state.bvalid) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = RESP_OKAY;
            if (state.aw_addr == FILTER_CONTROL_ADDR) begin
                if (state.w_strb[0]) begin
                    next_state.filter_ctrl[7:0] = state.w_data[7:0];
                end
                if (state.w_strb[1]) begin
                    next_state.filter_ctrl[15:8] = state.w_data[15:8];
                end
                next_state.restart = 1'b1;
            end else if (state.aw_addr == MODE_CONTROL_ADDR) begin
                if (state.w_strb[0]) begin
                    next_state.mode_ctrl = state.w_data[2:0];
                end
                next_state.restart = 1'b1;
            end else if (state.aw_addr != FILTER_STATUS_ADDR) begin
                next_state.bresp = RESP_SLVERR;
            end
        end
        next_state.awready = !next_state.aw_held;
        next_state.wready = !next_state.w_held;

        // Read channel, one read in flight
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state.arready) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = read_word;
            if (s_axi_araddr == FILTER_CONTROL_ADDR ||
                s_axi_araddr == MODE_CONTROL_ADDR ||
                s_axi_araddr == FILTER_STATUS_ADDR) begin
                next_state.rresp = RESP_OKAY;
            end else begin
                next_state.rresp = RESP_SLVERR;
            end
        end
        next_state.arready = !next_state.rvalid;

        // Chopping always brings in the pair average
        next_state.ravg_active =
            next_state.filter_ctrl[CHOP_BIT] |
            next_state.filter_ctrl[RAVG_BIT];

        // Conversion sequence
        case (state.seq)
            SEQ_IDLE: begin
                next_state.tick_cnt = 18'h0;
            end
            SEQ_DELAY: begin
                if (state.delay_cnt == 16'h0) begin
                    next_state.seq = SEQ_SETTLE;
                    next_state.tick_cnt = 18'h0;
                    next_state.settle_cnt = 3'h0;
                end else begin
                    next_state.delay_cnt = state.delay_cnt - 16'h1;
                end
            end
            SEQ_SETTLE, SEQ_RUN: begin
                if (tick) begin
                    if (state.tick_cnt + 18'h1 >= period) begin
                        next_state.tick_cnt = 18'h0;
                        if (state.seq == SEQ_RUN) begin
                            next_state.result_strobe = 1'b1;
                        end else if (state.settle_cnt + 3'h1
                                     >= settle_periods) begin
                            next_state.result_strobe = 1'b1;
                            next_state.seq = SEQ_RUN;
                        end else begin
                            next_state.settle_cnt =
                                state.settle_cnt + 3'h1;
                        end
                    end else begin
                        next_state.tick_cnt = state.tick_cnt + 18'h1;
                    end
                end
            end
            default: begin
                next_state.seq = SEQ_IDLE;
            end
        endcase

        // Restart both converters under the new settings
        if (state.restart) begin
            next_state.restart = 1'b0;
            next_state.converter_reset = 1'b1;
            next_state.tick_cnt = 18'h0;
            next_state.settle_cnt = 3'h0;
            next_state.delay_cnt =
                16'(DELAY_CYCLES * int'(enabled_count));
            if (enabled_count == 2'h0) begin
                next_state.seq = SEQ_IDLE;
            end else begin
                next_state.seq = SEQ_DELAY;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign converter_reset = state.converter_reset;
    assign modulator_tick = tick;
    assign result_strobe = state.result_strobe;
    assign chop_active = state.filter_ctrl[CHOP_BIT];
    assign running_average_active = state.ravg_active;
    assign averaging_factor = state.filter_ctrl[AF_LSB +: 6];
    assign second_notch_enable = state.filter_ctrl[NOTCH_BIT];
    assign decimation_factor = state.filter_ctrl[SF_LSB +: 7];
    assign low_power_mode = state.mode_ctrl[MODE_LOW_POWER_BIT];
endmodule : adc_decimation_filter_control

// file: design/modulator_ticker.sv
// Modulator clock tick generator, a phase accumulator on aclk.
// Assumes aclk at 125 MHz; low_power selects the slow oscillator rate.
`timescale 1ns/1ps
module modulator_ticker
    import adc_filter_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic low_power,
    output logic tick
);
    typedef struct packed {
        logic [31:0] phase;
        logic tick;
    } ticker_state_type;

    ticker_state_type state;
    ticker_state_type next_state;
    logic [32:0] sum;

    // ------------------------------------------------------------
    // Phase step, carry out gives one tick per modulator cycle
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        sum = {1'b0, state.phase} +
            {1'b0, low_power ? LOW_POWER_PHASE_STEP
                             : NORMAL_PHASE_STEP};
        next_state.phase = sum[31:0];
        next_state.tick = sum[32];
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule : modulator_ticker

// file: design/rate_period_calc.sv
// Output period and settling count from the filter settings.
// Assumes settings are stable register outputs; result is one cycle late.
`timescale 1ns/1ps
module rate_period_calc
    import adc_filter_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [6:0] sf,
    input wire logic [5:0] af,
    input wire logic chop,
    input wire logic ravg,
    input wire logic low_power,
    output logic [17:0] period,
    output logic [2:0] settle_periods
);
    typedef struct packed {
        logic [17:0] period;
        logic [2:0] settle;
    } calc_state_type;

    calc_state_type state;
    calc_state_type next_state;
    logic [31:0] base;
    logic [31:0] scaled;
    logic [31:0] raw;
    logic [31:0] limit;

    // ------------------------------------------------------------
    // Period in modulator ticks
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        base = (32'(sf) + 32'h1) * DECIM_BLOCK;
        scaled = base * (32'(af) + AVG_OFFSET);
        if (chop) begin
            raw = scaled + CHOP_EXTRA;
        end else if (af != 6'h0) begin
            raw = scaled;
        end else begin
            raw = base;
        end
        // Fixed mains-rejection rates above the formula range
        if (sf == SF_FORCE_60) begin
            raw = low_power ? LOW_60_PERIOD : NORMAL_60_PERIOD;
        end else if (sf == SF_FORCE_50) begin
            raw = low_power ? LOW_50_PERIOD : NORMAL_50_PERIOD;
        end
        limit = low_power ? LOW_MAX_PERIOD : NORMAL_MAX_PERIOD;
        if (raw > limit) begin
            raw = limit;
        end
        next_state.period = raw[17:0];
        // Settling in output periods
        if (chop) begin
            next_state.settle = SETTLE_CHOP;
        end else if (af != 6'h0) begin
            next_state.settle = ravg ? SETTLE_AVG_RAVG : SETTLE_AVG;
        end else begin
            next_state.settle = ravg ? SETTLE_RAVG : SETTLE_PLAIN;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign period = state.period;
    assign settle_periods = state.settle;
endmodule : rate_period_calc

// file: dv/adc_filter_chk.sv
// Assertion checker for the filter control block.
// Sees only top ports; bound below.
`timescale 1ns/1ps
module adc_filter_chk
    import adc_filter_pkg::*;
#(
    parameter int DELAY_CYCLES = 20
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic converter_reset,
    input wire logic modulator_tick,
    input wire logic result_strobe,
    input wire logic chop_active,
    input wire logic running_average_active,
    input wire logic [5:0] averaging_factor,
    input wire logic second_notch_enable,
    input wire logic [6:0] decimation_factor,
    input wire logic low_power_mode
);
    logic [31:0] wa;
    logic [15:0] wd;
    logic [3:0] ws;
    logic [17:0] since;
    logic [10:0] gap;
    logic same;
    logic lp_q;
    // Capture of the write under way
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            wa <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata[15:0];
            ws <= s_axi_wstrb;
        end
    end
    // Restart age and tick spacing
    always_ff @(posedge aclk) begin
        if (!aresetn || converter_reset) begin
            since <= '0;
        end else if (since != '1) begin
            since <= since + 18'h1;
        end
        if (!aresetn || low_power_mode != lp_q) begin
            same <= 1'b0;
        end else if (modulator_tick) begin
            same <= 1'b1;
        end
        gap <= modulator_tick ? 11'h1 : gap + 11'h1;
        lp_q <= low_power_mode;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ravg_chop;
        chop_active |-> running_average_active;
    endproperty
    a_ravg_chop: assert property (p_ravg_chop)
        else $error("pair average off");
    property p_defaults;
        $rose(aresetn) |-> decimation_factor == 7'h07 && !chop_active
            && averaging_factor == 6'h0 && !second_notch_enable;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("reset settings");
    property p_restart;
        $rose(s_axi_bvalid) && wa == FILTER_CONTROL_ADDR |=> converter_reset;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart");
    property p_pulse;
        converter_reset |=> !converter_reset;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("long restart");
    property p_fields;
        $rose(s_axi_bvalid) && wa == FILTER_CONTROL_ADDR && ws[1:0] == 2'h3
        |-> ##[0:1] chop_active == wd[15] && {averaging_factor,
            second_notch_enable, decimation_factor} == wd[13:0];
    endproperty
    a_fields: assert property (p_fields)
        else $error("fields differ");
    property p_unmapped;
        $rose(s_axi_bvalid) && wa != FILTER_CONTROL_ADDR
        && wa != MODE_CONTROL_ADDR && wa != FILTER_STATUS_ADDR
        |-> s_axi_bresp == RESP_SLVERR ##1 !converter_reset;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped write");
    property p_start_delay;
        result_strobe |-> since >= 18'(DELAY_CYCLES);
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("early result");
    property p_tick;
        modulator_tick && same |-> (low_power_mode
            ? gap >= 11'h3b8 && gap <= 11'h3bb : gap >= 11'hf3 && gap <= 11'hf6);
    endproperty
    a_tick: assert property (p_tick)
        else $error("tick spacing");
    c_restart: cover property (converter_reset);
    c_result: cover property (result_strobe);
    c_chop: cover property (chop_active && low_power_mode);
endmodule : adc_filter_chk

bind adc_decimation_filter_control adc_filter_chk #(
    .DELAY_CYCLES(DELAY_CYCLES)) adc_filter_chk_i (.*);

// file: dv/tb_top.sv
// Self-checking bench for the filter control block.
// Drives the bus directly; short start delay.
`timescale 1ns/1ps
module tb_top;
    import adc_filter_pkg::*;
    localparam int DLY = 20;
    logic aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, converter_reset, result_strobe, chop_active;
    logic running_average_active, second_notch_enable, low_power_mode;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [5:0] averaging_factor;
    logic [6:0] decimation_factor;
    int fails = 0, cmp_count = 0, pulses = 0, cyc = 0;
    adc_decimation_filter_control #(.DELAY_CYCLES(DLY))
        adc_decimation_filter_control_i (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .converter_reset, .modulator_tick(), .result_strobe, .chop_active,
        .running_average_active, .averaging_factor, .second_notch_enable,
        .decimation_factor, .low_power_mode);
    // Clock, restart counter and hang limit
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        pulses += (converter_reset === 1'b1);
        cyc++;
        if (cyc == 100000) begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_configs();
        logic [2:0] md[12] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3};
        // Only permitted factor pairs are written
        logic [15:0] fc[12] = '{16'h0007, 16'h4007, 16'h0207, 16'h4207,
            16'h8007, 16'h8207, 16'h00fe, 16'h007f, 16'h3f1f, 16'h007e,
            16'h3f1f, 16'h0007};
        int per[12] = '{512, 512, 2560, 2560, 1539, 2563, 8533, 10240,
            128000, 2184, 131072, 512};
        int st[12] = '{3, 4, 1, 2, 2, 2, 3, 3, 1, 3, 1, 3};
        logic [31:0] d;
        logic [1:0] r;
        int p;
        rd(FILTER_CONTROL_ADDR, d, r);
        chk(d, 32'h0007, "reset");
        for (int i = 0; i < 12; i++) begin
            p = pulses;
            wr(MODE_CONTROL_ADDR, 32'(md[i]), r);
            wr(FILTER_CONTROL_ADDR, 32'(fc[i]), r);
            chk(32'(r), 32'(RESP_OKAY), "write resp");
            repeat (2) @(posedge aclk);
            chk(pulses - p, 2, "restarts");
            chk(32'(chop_active), 32'(fc[i][15]), "chop");
            chk(32'(running_average_active), 32'(fc[i][15] | fc[i][14]),
                "pair average");
            chk(32'({averaging_factor, second_notch_enable,
                decimation_factor}), 32'(fc[i][13:0]), "fields");
            chk(32'(low_power_mode), 32'(md[i][0]), "low power");
            rd(FILTER_STATUS_ADDR, d, r);
            chk(32'(d[17:0]), 32'(per[i]), "period");
            chk(32'(d[22:20]), 32'(st[i]), "settling");
            rd(FILTER_CONTROL_ADDR, d, r);
            chk(d, 32'(fc[i]), "read back");
        end
        $display("test configs done");
    endtask : t_configs
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        int p;
        p = pulses;
        wr(32'hffff0600, 32'h00001234, r);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped resp");
        repeat (2) @(posedge aclk);
        chk(pulses - p, 0, "unmapped restart");
        rd(32'hffff0600, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
        rd(FILTER_CONTROL_ADDR, d, r);
        chk(d, 32'h0007, "unmapped changed");
        wr(MODE_CONTROL_ADDR, 32'h0, r);
        rd(FILTER_STATUS_ADDR, d, r);
        chk(32'(d[25:24]), 0, "idle");
        $display("test unmapped done");
    endtask : t_unmapped
    task automatic t_timing();
        logic [1:0] r;
        int c;
        wr(MODE_CONTROL_ADDR, 32'h6, r);
        wr(FILTER_CONTROL_ADDR, 32'h0, r);
        while (converter_reset !== 1'b1) @(posedge aclk);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (result_strobe !== 1'b1);
        chk(32'(c >= 2 * DLY + 46848 - 250 && c <= 2 * DLY + 47040 + 250),
            1, "first result");
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (result_strobe !== 1'b1);
        chk(32'(c >= 15614 && c <= 15682), 1, "result spacing");
        $display("test timing done");
    endtask : t_timing
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_configs();
        t_unmapped();
        t_timing();
        report_and_stop();
    end
endmodule : tb_top

// file: inc/adc_filter_pkg.sv
// Constants shared by the decimation filter control block.
// Assumes a single 125 MHz aclk domain and an AXI4-Lite register bus.
package adc_filter_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] FILTER_CONTROL_ADDR = 32'hffff0514;
    localparam logic [31:0] MODE_CONTROL_ADDR = 32'hffff0540;
    localparam logic [31:0] FILTER_STATUS_ADDR = 32'hffff0544;
    localparam logic [15:0] FILTER_CONTROL_RESET = 16'h0007;
    localparam logic [2:0] MODE_CONTROL_RESET = 3'h2;
    localparam int CHOP_BIT = 15;
    localparam int RAVG_BIT = 14;
    localparam int AF_LSB = 8;
    localparam int NOTCH_BIT = 7;
    localparam int SF_LSB = 0;
    localparam int MODE_LOW_POWER_BIT = 0;
    localparam int MODE_PRIMARY_BIT = 1;
    localparam int MODE_AUX_BIT = 2;
    localparam int STATUS_SETTLE_LSB = 20;
    localparam int STATUS_SEQ_LSB = 24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Clocks and rates
    // ------------------------------------------------------------
    localparam longint ACLK_HZ = 125000000;
    localparam longint ACLK_PERIOD_NS = 8;
    localparam longint NORMAL_MOD_HZ = 512000;
    localparam longint LOW_POWER_MOD_HZ = 131072;
    localparam logic [31:0] NORMAL_PHASE_STEP =
        32'((NORMAL_MOD_HZ << 32) / ACLK_HZ);
    localparam logic [31:0] LOW_POWER_PHASE_STEP =
        32'((LOW_POWER_MOD_HZ << 32) / ACLK_HZ);
    localparam logic [31:0] DECIM_BLOCK = 32'h40;
    localparam logic [31:0] AVG_OFFSET = 32'h3;
    localparam logic [31:0] CHOP_EXTRA = 32'h3;
    localparam logic [6:0] SF_FORCE_60 = 7'h7e;
    localparam logic [6:0] SF_FORCE_50 = 7'h7f;
    localparam longint FORCED_HZ_A = 60;
    localparam longint FORCED_HZ_B = 50;
    localparam longint SLOWEST_NORMAL_HZ = 4;
    localparam longint SLOWEST_LOW_POWER_HZ = 1;
    localparam logic [31:0] NORMAL_60_PERIOD = 32'(NORMAL_MOD_HZ / FORCED_HZ_A);
    localparam logic [31:0] NORMAL_50_PERIOD = 32'(NORMAL_MOD_HZ / FORCED_HZ_B);
    localparam logic [31:0] LOW_60_PERIOD = 32'(LOW_POWER_MOD_HZ / FORCED_HZ_A);
    localparam logic [31:0] LOW_50_PERIOD = 32'(LOW_POWER_MOD_HZ / FORCED_HZ_B);
    localparam logic [31:0] NORMAL_MAX_PERIOD =
        32'(NORMAL_MOD_HZ / SLOWEST_NORMAL_HZ);
    localparam logic [31:0] LOW_MAX_PERIOD =
        32'(LOW_POWER_MOD_HZ / SLOWEST_LOW_POWER_HZ);
    // ------------------------------------------------------------
    // Settling and start-up delay
    // ------------------------------------------------------------
    localparam logic [2:0] SETTLE_PLAIN = 3'h3;
    localparam logic [2:0] SETTLE_RAVG = 3'h4;
    localparam logic [2:0] SETTLE_AVG = 3'h1;
    localparam logic [2:0] SETTLE_AVG_RAVG = 3'h2;
    localparam logic [2:0] SETTLE_CHOP = 3'h2;
    localparam longint CONVERTER_DELAY_NS = 60000;
    localparam int CONVERTER_DELAY_CYCLES =
        int'((CONVERTER_DELAY_NS + ACLK_PERIOD_NS - 1) / ACLK_PERIOD_NS);
endpackage : adc_filter_pkg
